// file: inc/ea_gen_pkg.sv
package ea_gen_pkg;

    // ==========================================================
    // Widths and register file
    // ==========================================================
    localparam int ADDR_W = 32;
    localparam int REG_SEL_W = 3;
    localparam int NUM_GPR = 8;
    localparam logic [2:0] STACK_PTR_SEL = 3'h4;
    localparam logic [ADDR_W-1:0] REAL_LIMIT = 32'h0000FFFF;
    localparam int HALF_W = 16;

    // ==========================================================
    // Encodings
    // ==========================================================
    typedef enum logic [1:0] {
        SCALE_1 = 2'h0,
        SCALE_2 = 2'h1,
        SCALE_4 = 2'h2,
        SCALE_8 = 2'h3
    } scale_type;

    typedef enum logic [1:0] {
        DISP_NONE = 2'h0,
        DISP_8 = 2'h1,
        DISP_16 = 2'h2,
        DISP_32 = 2'h3
    } disp_size_type;

    typedef enum logic [1:0] {
        OPND_MEM = 2'h0,
        OPND_REG = 2'h1,
        OPND_IMM = 2'h2
    } opnd_kind_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SUM = 2'h1,
        ST_DONE = 2'h2
    } ea_state_type;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        opnd_kind_type kind;
        logic base_en;
        logic [REG_SEL_W-1:0] base_sel;
        logic index_en;
        logic [REG_SEL_W-1:0] index_sel;
        scale_type scale;
        disp_size_type disp_size;
        logic [ADDR_W-1:0] disp;
        logic [REG_SEL_W-1:0] reg_sel;
        logic [ADDR_W-1:0] imm;
        logic default_big;
        logic real_mode;
        logic opnd_prefix;
        logic addr_prefix;
    } ea_req_type;

    typedef struct packed {
        logic [ADDR_W-1:0] linear;
        logic [ADDR_W-1:0] offset;
        logic [ADDR_W-1:0] operand;
        logic addr32;
        logic opnd32;
        logic gp_fault;
        logic bad_form;
    } ea_rsp_type;

endpackage

// file: rtl/effective_address_generator.sv
// Overview of operation
// (RL1) Linear address is segment base plus effective address.
// (RL2) Effective address is base plus scaled index plus displacement.
// (RL3) Index is scaled only by one, two, four or eight.
// (RL4) Stack pointer register is never an index; others may be.
// (RL5) 32-bit addressing takes 8- or 32-bit displacements, any base, any index but the stack pointer.
// (RL6) 16-bit addressing takes only 8- or 16-bit displacements.
// (RL7) No extra cycles except one more when base and index both used.
// (RL8) Nine memory modes built from the four components.
// (RL9) Direct mode takes offset straight from the displacement.
// (RL10) Default-size bit 0 gives 16-bit sizes, 1 gives 32-bit.
// (RL11) Real mode defaults to 16-bit operand and address sizes.
// (RL12) Size prefixes invert the default for one instruction only.
// (RL13) Real mode faults on addresses beyond FFFFh even with prefix.
// (RL14) Address prefix permits extended forms, not a wider real range.
// (RL15) Register and immediate operands are also supported.
// (RL16) Sum is truncated to address size before fault check and base add.
`timescale 1ns/1ps
`default_nettype none

module effective_address_generator
    import ea_gen_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire ea_req_type req_i,
    input wire logic [ADDR_W-1:0] seg_base_i,
    input wire logic [NUM_GPR*ADDR_W-1:0] gpr_i,
    output logic busy_o,
    output logic rsp_valid_o,
    output ea_rsp_type rsp_o
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [ADDR_W-1:0] pick_gpr(
        input logic [NUM_GPR*ADDR_W-1:0] file,
        input logic [REG_SEL_W-1:0] sel
    );
        pick_gpr = file[sel*ADDR_W +: ADDR_W];
    endfunction

    function automatic logic [ADDR_W-1:0] fit(
        input logic [ADDR_W-1:0] v,
        input logic wide
    );
        fit = wide ? v : {{HALF_W{1'b0}}, v[HALF_W-1:0]};
    endfunction

    // Displacements are sign-extended, so a short negative one reaches back.
    function automatic logic [ADDR_W-1:0] ext_disp(
        input logic [ADDR_W-1:0] d,
        input disp_size_type sz
    );
        unique case (sz)
            DISP_NONE: ext_disp = '0;
            DISP_8: ext_disp = {{24{d[7]}}, d[7:0]};
            DISP_16: ext_disp = {{HALF_W{d[15]}}, d[15:0]};
            DISP_32: ext_disp = d;
        endcase
    endfunction

    // ==========================================================
    // Combinational address formation
    // ==========================================================
    ea_state_type state_r;
    ea_req_type hold_r;
    logic [ADDR_W-1:0] seg_r;
    logic [ADDR_W-1:0] part_r;
    ea_req_type cur;
    logic addr32;
    logic opnd32;
    logic [ADDR_W-1:0] base_v;
    logic [ADDR_W-1:0] index_v;
    logic [ADDR_W-1:0] disp_v;
    logic [ADDR_W-1:0] base_plus_disp;
    logic [ADDR_W-1:0] ea_sum;
    logic bad_form;
    logic two_step;

    assign cur = (state_r == ST_SUM) ? hold_r : req_i;
    // Real mode forces 16-bit default regardless of D bit. [RL10] [RL11]
    // Prefix inverts default for this request only. [RL12]
    assign addr32 = (cur.default_big & ~cur.real_mode) ^ cur.addr_prefix;
    assign opnd32 = (cur.default_big & ~cur.real_mode) ^ cur.opnd_prefix;

    always_comb begin
        base_v = cur.base_en ? pick_gpr(gpr_i, cur.base_sel) : '0; // [RL2]
        index_v = '0;
        if (cur.index_en && cur.index_sel != STACK_PTR_SEL) begin // [RL4]
            index_v = pick_gpr(gpr_i, cur.index_sel) << cur.scale; // [RL3]
        end
        disp_v = ext_disp(cur.disp, cur.disp_size);
        base_plus_disp = base_v + disp_v;
        // Direct mode falls out with base and index absent. [RL9] [RL8]
        // Truncation comes first: a 16-bit sum wraps rather than faults.
        ea_sum = fit(((state_r == ST_SUM) ? part_r : base_plus_disp)
            + index_v, addr32); // [RL16] [RL2]
    end

    // ==========================================================
    // Form checks
    // ==========================================================
    always_comb begin
        // 16-bit forms: no 32-bit displacement; a scaled
        // index is an extended form that needs the address prefix.
        bad_form = 1'b0;
        if (cur.kind == OPND_MEM) begin
            if (addr32) begin
                bad_form = (cur.disp_size == DISP_16); // [RL5]
            end else begin
                bad_form = (cur.disp_size == DISP_32) // [RL6]
                    || (cur.index_en && cur.scale != SCALE_1); // [RL14]
            end
            bad_form = bad_form
                || (cur.index_en && cur.index_sel == STACK_PTR_SEL); // [RL4]
            if (!cur.base_en && !cur.index_en
                && cur.disp_size == DISP_NONE) begin
                bad_form = 1'b1; // [RL8]
            end
        end
    end

    // Base and index together take a second adder pass. [RL7]
    // The register file is read again in the second pass; it must hold still.
    assign two_step = req_i.kind == OPND_MEM && req_i.base_en
        && req_i.index_en;

    // ==========================================================
    // Sequencing
    // ==========================================================
    // Requests during the second pass are dropped; busy_o tells the decoder.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            hold_r <= '0;
            seg_r <= '0;
            part_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_DONE: begin
                    if (req_valid_i && two_step) begin
                        state_r <= ST_SUM; // [RL7]
                        hold_r <= req_i;
                        seg_r <= seg_base_i;
                        part_r <= base_plus_disp;
                    end else begin
                        state_r <= req_valid_i ? ST_DONE : ST_IDLE;
                    end
                end
                ST_SUM: begin
                    state_r <= ST_DONE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Result registers
    // ==========================================================
    logic take;
    logic [ADDR_W-1:0] seg_now;
    // A response leaves on each single-step request taken outside the second pass and on each second pass.
    assign take = (state_r == ST_SUM) || (req_valid_i && !two_step
        && state_r != ST_SUM);
    assign seg_now = (state_r == ST_SUM) ? seg_r : seg_base_i;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= take;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_r != ST_SUM) && req_valid_i && two_step;
        end
    end

    // The response holds until the next one, so it may be read late.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_o <= '0;
        end else begin
            if (take) begin
                rsp_o.addr32 <= addr32;
                rsp_o.opnd32 <= opnd32;
                rsp_o.offset <= '0;
                rsp_o.linear <= '0;
                rsp_o.operand <= '0;
                rsp_o.gp_fault <= 1'b0;
                rsp_o.bad_form <= 1'b0;
                unique case (cur.kind)
                    OPND_REG: begin
                        rsp_o.operand <= fit(pick_gpr(gpr_i, cur.reg_sel),
                            opnd32); // [RL15]
                    end
                    OPND_IMM: begin
                        rsp_o.operand <= fit(cur.imm, opnd32); // [RL15]
                    end
                    default: begin
                        rsp_o.offset <= ea_sum;
                        rsp_o.linear <= seg_now + ea_sum; // [RL1]
                        rsp_o.bad_form <= bad_form;
                        // Prefix never widens the real-mode range. [RL13]
                        rsp_o.gp_fault <= cur.real_mode
                            && (ea_sum > REAL_LIMIT); // [RL14]
                    end
                endcase
            end
        end
    end

endmodule // effective_address_generator

`default_nettype wire

// file: verif/gpr_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_model
    import ea_gen_pkg::*;
(
    output logic [NUM_GPR*ADDR_W-1:0] gpr_o
);
    // ====
    // Fixed contents keep both steps of a request on the same operands.
    always_comb begin
        for (int n = 0; n < NUM_GPR; n++) begin
            gpr_o[n*ADDR_W+:ADDR_W] = ADDR_W'(32'h1000 * (n + 1));
        end
    end
endmodule // gpr_model
`default_nettype wire

// file: verif/ea_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ea_monitor
    import ea_gen_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire ea_req_type req_i,
    input wire logic [ADDR_W-1:0] seg_base_i,
    input wire logic busy_o,
    input wire logic rsp_valid_o,
    input wire ea_rsp_type rsp_o
);
    // ====
    // Results are judged against the request as it was taken.
    logic tk;
    logic two;
    ea_req_type q_r;
    logic [ADDR_W-1:0] s_r;
    logic dflt;
    assign tk = req_valid_i && !busy_o;
    assign two = req_i.kind == OPND_MEM && req_i.base_en && req_i.index_en;
    assign dflt = q_r.default_big & ~q_r.real_mode;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= '0;
            s_r <= '0;
        end else if (tk) begin
            q_r <= req_i;
            s_r <= seg_base_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    chk_one_step: assert property (tk && !two |=> rsp_valid_o)
        else $error("late answer");
    chk_two_step: assert property (
        tk && two |=> busy_o && !rsp_valid_o ##1 rsp_valid_o)
        else $error("two-step timing");
    chk_linear_sum: assert property (
        rsp_valid_o && q_r.kind == OPND_MEM |->
        rsp_o.linear == s_r + rsp_o.offset) else $error("linear sum");
    chk_addr_size: assert property (
        rsp_valid_o |-> rsp_o.addr32 == (dflt ^ q_r.addr_prefix))
        else $error("address size");
    chk_opnd_size: assert property (
        rsp_valid_o |-> rsp_o.opnd32 == (dflt ^ q_r.opnd_prefix))
        else $error("operand size");
    chk_real_fault: assert property (
        rsp_valid_o |-> rsp_o.gp_fault ==
        (q_r.real_mode && rsp_o.offset > REAL_LIMIT)) else $error("fault");
    chk_half_trunc: assert property (
        rsp_valid_o && !rsp_o.addr32 |-> rsp_o.offset[31:16] == 16'h0)
        else $error("offset width");
    chk_index_sp: assert property (
        rsp_valid_o && q_r.index_en && q_r.index_sel == STACK_PTR_SEL
        |-> rsp_o.bad_form) else $error("stack index taken");
    cover property (tk && two);
    cover property (rsp_valid_o && rsp_o.gp_fault);
    cover property (rsp_valid_o && rsp_o.bad_form);
endmodule // ea_monitor
`default_nettype wire

// file: verif/tb_effective_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_effective_address_generator
    import ea_gen_pkg::*;
;
    logic mclk_i;
    logic nrst_i = 1'h0;
    logic req_valid_i = 1'h0;
    logic busy_o;
    logic rsp_valid_o;
    ea_req_type req_i = '0;
    ea_rsp_type rsp_o;
    logic [ADDR_W-1:0] seg_base_i = 32'h20000;
    logic [NUM_GPR*ADDR_W-1:0] gpr_i;
    int n_fail = 0;
    int checked = 0;
    effective_address_generator effective_address_generator_i (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .seg_base_i(seg_base_i), .gpr_i(gpr_i),
        .busy_o(busy_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
    gpr_model gpr_model_i (.gpr_o(gpr_i));
    initial begin
        mclk_i = 1'h0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic wrap_up;
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_flag(input string nm, input logic e, g);
        cmp(nm, {31'h0, e}, {31'h0, g});
    endtask
    function automatic ea_req_type rq(input logic [7:0] bx, scale_type sc,
            disp_size_type dz, logic [31:0] d);
        return {OPND_MEM, bx, sc, dz, d, 35'h0, 4'h8};
    endfunction
    // ====
    // Base plus index costs a cycle, so latency follows from the request.
    task automatic run(input ea_req_type r, logic [31:0] e, logic [1:0] ef);
        int lat;
        int lx;
        lx = (r.kind == OPND_MEM && r.base_en && r.index_en) ? 2 : 1;
        @(posedge mclk_i);
        req_i <= r;
        req_valid_i <= 1'h1;
        @(posedge mclk_i);
        req_valid_i <= 1'h0;
        lat = 1;
        #1;
        cmp_flag("busy", lx == 2, busy_o);
        while (rsp_valid_o !== 1'h1 && lat < 4) begin
            @(posedge mclk_i);
            lat++;
            #1;
        end
        cmp("latency", 32'(lx), 32'(lat));
        if (r.kind == OPND_MEM) begin
            cmp("offset", e, rsp_o.offset);
            cmp("linear", seg_base_i + e, rsp_o.linear);
        end else cmp("operand", e, rsp_o.operand);
        cmp_flag("bad_form", ef[1], rsp_o.bad_form);
        cmp_flag("gp_fault", ef[0], rsp_o.gp_fault);
    endtask
    task automatic t_modes;
        run(rq(8'h00, SCALE_1, DISP_8, 32'hF0), 32'hFFFFFFF0, 2'h0);
        run(rq(8'h90, SCALE_1, DISP_NONE, 32'h0), 32'h2000, 2'h0);
        run(rq(8'h90, SCALE_1, DISP_8, 32'h24), 32'h2024, 2'h0);
        run(rq(8'h0B, SCALE_1, DISP_32, 32'h100), 32'h4100, 2'h0);
        run(rq(8'h0B, SCALE_4, DISP_32, 32'h100), 32'h10100, 2'h0);
        run(rq(8'h9B, SCALE_1, DISP_NONE, 32'h0), 32'h6000, 2'h0);
        run(rq(8'h8D, SCALE_8, DISP_NONE, 32'h0), 32'h31000, 2'h0);
        run(rq(8'h9B, SCALE_1, DISP_32, 32'hFFF0), 32'h15FF0, 2'h0);
        run(rq(8'hFE, SCALE_2, DISP_8, 32'h50), 32'h16050, 2'h0);
    endtask
    task automatic t_sizes;
        ea_req_type r;
        for (int i = 0; i < 16; i++) begin
            r = rq(8'h00, SCALE_1, DISP_8, 32'h10);
            r[3:0] = 4'(i);
            run(r, 32'h10, 2'h0);
            cmp_flag("addr32", (i[3] & ~i[2]) ^ i[0], rsp_o.addr32);
            cmp_flag("opnd32", (i[3] & ~i[2]) ^ i[1], rsp_o.opnd32);
        end
    endtask
    task automatic t_limits;
        ea_req_type r;
        r = rq(8'h00, SCALE_1, DISP_32, 32'hFFFF);
        r[3:0] = 4'h5;
        run(r, 32'hFFFF, 2'h0);
        r.disp = 32'h10000;
        run(r, 32'h10000, 2'h1);
        r = rq(8'hF0, SCALE_1, DISP_16, 32'h9000);
        r.default_big = 1'h0;
        run(r, 32'h1000, 2'h0);
        r = rq(8'h0B, SCALE_2, DISP_8, 32'h10);
        r.default_big = 1'h0;
        run(r, 32'h8010, 2'h2);
        r.addr_prefix = 1'h1;
        run(r, 32'h8010, 2'h0);
    endtask
    task automatic t_forms;
        ea_req_type r;
        logic [31:0] g;
        for (int n = 0; n < NUM_GPR; n++) begin
            g = 32'h1000 * (n + 1) + 32'h10;
            run(rq({1'h1, 3'(n), 4'h0}, SCALE_1, DISP_8, 32'h10), g,
                2'h0);
            r = rq({4'h1, 1'h1, 3'(n)} & 8'h0F, SCALE_1, DISP_8, 32'h10);
            if (n == 4) run(r, 32'h10, 2'h2);
            else run(r, g, 2'h0);
        end
        r = rq(8'h00, SCALE_1, DISP_16, 32'h10);
        run(r, 32'h10, 2'h2);
        r.default_big = 1'h0;
        r.disp_size = DISP_32;
        run(r, 32'h10, 2'h2);
        run(rq(8'h00, SCALE_1, DISP_NONE, 32'h0), 32'h0, 2'h2);
    endtask
    task automatic t_operands;
        ea_req_type r;
        r = '0;
        r.kind = OPND_REG;
        r.reg_sel = 3'h5;
        r.default_big = 1'h1;
        run(r, 32'h6000, 2'h0);
        r.kind = OPND_IMM;
        r.imm = 32'h12345678;
        r.default_big = 1'h0;
        run(r, 32'h5678, 2'h0);
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'h1;
        t_modes();
        t_sizes();
        t_limits();
        t_forms();
        t_operands();
        wrap_up();
    end
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule // tb_effective_address_generator
bind effective_address_generator ea_monitor ea_monitor_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .seg_base_i(seg_base_i), .busy_o(busy_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
`default_nettype wire
